// >>> shared/pscw_pkg.sv
// Shared constants for the serial control word decoder of the power manager.
// Assumes a single 100 MHz clock and a 48-bit word shifted in most significant bit first.
package pscw_pkg;

    // Word geometry.
    localparam int WORD_BITS = 48;
    localparam int CTRL_BITS = 40;
    localparam int PARITY_LSB = 40;
    localparam int TEST_LSB = 45;

    // Control word field positions.
    localparam int CH1_SEL_LSB = 8;
    localparam int HV_SEL_LSB = 6;
    localparam int HV_EN_BIT = 5;
    localparam int BACKUP_DIS_BIT = 4;
    localparam int BL_DUTY_LSB = 2;
    localparam int BL_CUR_LSB = 0;
    localparam int CH3_LOAD_SWITCH_LSB = 30;
    localparam int CH3_DUTY_LSB = 28;

    // Every control field defaults to code zero.
    localparam logic [39:0] CTRL_RESET = 40'h00_0000_0000;
    localparam logic [47:0] SETUP_RESET = 48'h0000_0000_0000;
    localparam logic [47:0] TRIM_RESET = 48'h0000_0000_0000;

    // Decoded values of the default codes, and the fixed duty limit.
    localparam logic [11:0] CH1_DEFAULT_MV = 12'haf0;
    localparam logic [15:0] HV_DEFAULT_MV = 16'h34bc;
    localparam logic [6:0] BL_DUTY_DEFAULT_PCT = 7'h59;
    localparam logic [7:0] BL_CUR_DEFAULT = 8'h78;
    localparam logic [6:0] CH3_DUTY_DEFAULT_PCT = 7'h56;
    localparam logic [6:0] FIXED_DUTY_PCT = 7'h5f;

    // Setup word fields.
    localparam int DT_A_LSB = 42;
    localparam int DT_RISE_B_LSB = 40;
    localparam int DT_RISE_C_LSB = 38;
    localparam int DT_FALL_B_LSB = 36;
    localparam int DT_FALL_C_LSB = 34;

    // Trim word fields.
    localparam int REF_TRIM_LSB = 40;
    localparam int OSC_TRIM_LSB = 37;
    localparam int GAIN_TRIM_LSB = 35;
    localparam int OFFS_TRIM_LSB = 33;

    // Fault history word positions.
    localparam int FAULT_BITS = 13;
    localparam int SHORT_CH7_BIT = 12;
    localparam int SHORT_CH1_LSB = 6;
    localparam int OV_CH2_LSB = 2;
    localparam int THERMAL_BIT = 1;

    // Dead time.
    localparam int CLOCK_MHZ = 100;
    localparam int DT_SHORT_NS = 30;
    localparam int DT_LONG_NS = 40;
    localparam int DT_SHORT_CYC = (DT_SHORT_NS * CLOCK_MHZ + 999) / 1000;
    localparam int DT_LONG_CYC = (DT_LONG_NS * CLOCK_MHZ + 999) / 1000;

    typedef enum logic [2:0] {
        TEST_NONE = 3'b000,
        SETUP_WRITE = 3'b001,
        SETUP_READ = 3'b010,
        FAULT_READ = 3'b011,
        TRIM_WRITE = 3'b100,
        TRIM_READ = 3'b101,
        TEST_SPARE6 = 3'b110,
        TEST_SPARE7 = 3'b111
    } pscw_test_type;

endpackage : pscw_pkg

// >>> hdl/pscw_pin_sync.sv
// Two-stage synchroniser with edge detection for a group of pins.
// Assumes the pins are asynchronous to clock; edges are one-cycle pulses.
`timescale 1ns/1ps
module pscw_pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pins
    input wire logic [WIDTH-1:0] pin,
    // Synchronised view
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
        logic [WIDTH-1:0] prev;
    } pscw_sync_type;

    pscw_sync_type state_reg;
    pscw_sync_type state_next;

    // The first stage feeds only the second stage.
    always_comb begin
        state_next.meta = pin;
        state_next.stable = state_reg.meta;
        state_next.prev = state_reg.stable;
        if (rst) begin
            state_next = '0;
        end
    end

    always_ff @(posedge clock) begin
        state_reg <= state_next;
    end

    assign level = state_reg.stable;
    assign rise = state_reg.stable & ~state_reg.prev;
    assign fall = ~state_reg.stable & state_reg.prev;
endmodule : pscw_pin_sync

// >>> hdl/pscw_ch1_decode.sv
// Channel-1 voltage code lookup, purely combinational.
// Assumes the caller registers the result.
`timescale 1ns/1ps
module pscw_ch1_decode (
    // Code
    input wire logic [3:0] code,
    // Target in millivolts
    output logic [11:0] millivolts,
    output logic not_recommended
);
    always_comb begin
        case (code)
            4'h0: millivolts = 12'haf0;
            4'h1: millivolts = 12'habe;
            4'h2: millivolts = 12'ha8c;
            4'h3: millivolts = 12'ha5a;
            4'h4: millivolts = 12'ha28;
            4'h5: millivolts = 12'h9f6;
            4'h6: millivolts = 12'h9c4;
            4'h7: millivolts = 12'hc80;
            4'h8: millivolts = 12'hc4e;
            4'h9: millivolts = 12'hc1c;
            4'ha: millivolts = 12'hbea;
            4'hb: millivolts = 12'hbb8;
            4'hc: millivolts = 12'hb86;
            4'hd: millivolts = 12'hb54;
            4'he: millivolts = 12'hb22;
            default: millivolts = 12'hb09;
        endcase
    end

    // The low settings are only flagged; the word is still honoured.
    assign not_recommended = (code == 4'h4) || (code == 4'h5) || (code == 4'h6);
endmodule : pscw_ch1_decode

// >>> hdl/pscw_decoder.sv
// Contract
// - Channel-1 code in bits 11:8 decodes to 2.50..3.20 V; zero gives 2.80 V.
// - Bits 7:6 select 13.5, 12.5, 12.0 or 8.5 V for high-voltage LDO.
// - Bit 5 enables the high-voltage LDO; disabled after reset.
// - Bit 4 high turns the backup LDO off; low leaves it on.
// - Bits 3:2 set backlight duty limit 89, 91, 93 or 95 percent.
// - Bits 1:0 set backlight current 12, 20, 8 mA or off.
// - Channels 1 boost and 8 follow channel-3 duty; buck and channel 2 fixed 95%.
// - Test code 011 returns the latched fault history on serial output.
// - History reports shorts at bit 12 and 10:6; bit 11 is always low.
// - History reports overvoltage of channels 7, 6, 3, 2 at bits 5..2.
// - History reports thermal shutdown at bit 1.
// - Code 001 writes the setup word, 010 reads it; bit 44 unused.
// - Code 100 writes the trim word, 101 reads it.
// - Setup word holds five 2-bit dead-time trims at bits 43..34.
// - Dead time is 30 ns on channels 1, 2, 3, 8 and 40 ns on 7.
// - Channel-3 switched output follows its load-switch field.
// - Backlight forced off with soft-start reset while reference is out of window.
// - Channel 7 runs step-up while its mode pin is high.
// - Channel-3 switched output turns on only for code 11.
// - Bits 47:40 of a control word carry parity.
//
// Serial control word decoder for the multi-channel power manager.
// Assumes every pin is asynchronous to clock and the serial clock is far slower than clock.
`timescale 1ns/1ps
module pscw_decoder (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Serial interface pins
    input wire logic serial_clk,
    input wire logic serial_din,
    input wire logic serial_latch,
    input wire logic test_select,
    output logic serial_dout,
    // Status pins
    input wire logic power_on,
    input wire logic ch1_buck_mode,
    input wire logic ch7_topology_select,
    input wire logic backlight_reference_pin,
    // Protection events
    input wire logic short_fault_ch1,
    input wire logic short_fault_ch2,
    input wire logic short_fault_ch3,
    input wire logic short_fault_ch4,
    input wire logic short_fault_ch5,
    input wire logic short_fault_ch7,
    input wire logic overvolt_fault_ch2,
    input wire logic overvolt_fault_ch3,
    input wire logic overvolt_fault_ch6,
    input wire logic overvolt_fault_ch7,
    input wire logic thermal_fault,
    // Decoded voltages and switches
    output logic [11:0] ch1_target_mv,
    output logic ch1_code_not_recommended,
    output logic [15:0] hv_linear_mv,
    output logic hv_linear_enable,
    output logic backup_linear_disable,
    output logic ch3_switched_output,
    output logic ch7_boost_mode,
    output logic [7:0] control_parity,
    // Backlight
    output logic [6:0] backlight_duty_pct,
    output logic [7:0] backlight_current_tenth_ma,
    output logic backlight_on,
    output logic backlight_softstart_reset,
    // Duty limits
    output logic [6:0] ch1_duty_pct,
    output logic [6:0] ch2_duty_pct,
    output logic [6:0] ch3_duty_pct,
    output logic [6:0] ch8_duty_pct,
    // Dead time
    output logic [3:0] deadtime_short_cycles,
    output logic [3:0] deadtime_long_cycles,
    output logic [1:0] deadtime_trim_a,
    output logic [1:0] rise_deadtime_trim_b,
    output logic [1:0] rise_deadtime_trim_c,
    output logic [1:0] fall_deadtime_trim_b,
    output logic [1:0] fall_deadtime_trim_c,
    // Trim and nonvolatile write
    output logic [4:0] reference_trim,
    output logic [2:0] oscillator_trim,
    output logic [1:0] amp_gain_trim,
    output logic [1:0] amp_offset_trim,
    output logic nv_write_strobe,
    output logic nv_write_select
);
    typedef struct packed {
        logic [47:0] shift_in;
        logic [47:0] shift_out;
        logic dout;
        logic [39:0] ctrl;
        logic [7:0] parity;
        logic [47:0] setup;
        logic [47:0] trim;
        logic [12:0] faults;
        logic nv_strobe;
        logic nv_select;
        logic [11:0] ch1_mv;
        logic ch1_warn;
        logic [15:0] hv_mv;
        logic hv_en;
        logic bk_dis;
        logic [6:0] bl_duty;
        logic [7:0] bl_cur;
        logic bl_on;
        logic bl_ss_rst;
        logic [6:0] ch3_duty;
        logic [6:0] ch1_duty;
        logic ch3_load_switch;
        logic ch7_boost;
    } pscw_state_type;

    pscw_state_type state_reg;
    pscw_state_type state_next;

    logic [3:0] ser_level;
    logic [3:0] ser_rise;
    logic [3:0] ser_fall;
    logic [14:0] stat_level;
    logic [14:0] stat_rise;
    logic [11:0] ch1_mv_w;
    logic ch1_warn_w;
    logic [12:0] fault_evt;
    pscw_pkg::pscw_test_type test_code;

    // Serial pins: bit 0 clock, 1 data, 2 latch, 3 test select.
    pscw_pin_sync #(
        .WIDTH(4)
    ) u_serial_sync (
        .clock(clock),
        .rst(rst),
        .pin({test_select, serial_latch, serial_din, serial_clk}),
        .level(ser_level),
        .rise(ser_rise),
        .fall(ser_fall)
    );

    pscw_pin_sync #(
        .WIDTH(15)
    ) u_status_sync (
        .clock(clock),
        .rst(rst),
        .pin({power_on, ch1_buck_mode, ch7_topology_select, backlight_reference_pin,
              short_fault_ch7, short_fault_ch5, short_fault_ch4, short_fault_ch3,
              short_fault_ch2, short_fault_ch1, overvolt_fault_ch7, overvolt_fault_ch6,
              overvolt_fault_ch3, overvolt_fault_ch2, thermal_fault}),
        .level(stat_level),
        .rise(stat_rise),
        .fall()
    );

    pscw_ch1_decode u_ch1_decode (
        .code(state_reg.ctrl[pscw_pkg::CH1_SEL_LSB +: 4]),
        .millivolts(ch1_mv_w),
        .not_recommended(ch1_warn_w)
    );

    // Bits 11 and 0 stay low.
    assign fault_evt = {stat_level[10], 1'b0, stat_level[9:5], stat_level[4:1],
                        stat_level[0], 1'b0};
    assign test_code = pscw_pkg::pscw_test_type'(
        state_reg.shift_in[pscw_pkg::TEST_LSB +: 3]);

    always_comb begin
        state_next = state_reg;
        state_next.nv_strobe = 1'b0;

        // Shift in at the rising link edge.
        if (ser_rise[0]) begin
            state_next.shift_in = {state_reg.shift_in[46:0], ser_level[1]};
        end
        // Readback moves on the fall, so it is steady at the host's rise.
        if (ser_fall[0]) begin
            state_next.shift_out = {state_reg.shift_out[46:0], 1'b0};
            state_next.dout = state_reg.shift_out[46];
        end

        // Power-on clears history; a fault in that cycle still sets.
        state_next.faults = (stat_rise[14] ? '0 : state_reg.faults) | fault_evt;

        if (ser_rise[2]) begin
            if (!ser_level[3]) begin
                // The whole word applies at once.
                state_next.ctrl = state_reg.shift_in[pscw_pkg::CTRL_BITS-1:0];
                state_next.parity = state_reg.shift_in[pscw_pkg::PARITY_LSB +: 8];
            end else begin
                case (test_code)
                    pscw_pkg::SETUP_WRITE: begin
                        state_next.setup = state_reg.shift_in;
                        state_next.nv_strobe = 1'b1;
                        state_next.nv_select = 1'b0;
                    end
                    pscw_pkg::SETUP_READ: begin
                        state_next.shift_out = state_reg.setup;
                        state_next.dout = state_reg.setup[47];
                    end
                    pscw_pkg::FAULT_READ: begin
                        state_next.shift_out = {pscw_pkg::FAULT_READ, 32'h0000_0000,
                                                state_reg.faults};
                        state_next.dout = 1'b0;
                    end
                    pscw_pkg::TRIM_WRITE: begin
                        state_next.trim = state_reg.shift_in;
                        state_next.nv_strobe = 1'b1;
                        state_next.nv_select = 1'b1;
                    end
                    pscw_pkg::TRIM_READ: begin
                        state_next.shift_out = state_reg.trim;
                        state_next.dout = state_reg.trim[47];
                    end
                    default: begin
                        state_next.shift_out = state_reg.shift_out;
                    end
                endcase
            end
        end

        // Decoded settings follow one cycle later, all together.
        state_next.ch1_mv = ch1_mv_w;
        state_next.ch1_warn = ch1_warn_w;
        case (state_reg.ctrl[pscw_pkg::HV_SEL_LSB +: 2])
            2'h0: state_next.hv_mv = 16'h34bc;
            2'h1: state_next.hv_mv = 16'h30d4;
            2'h2: state_next.hv_mv = 16'h2ee0;
            default: state_next.hv_mv = 16'h2134;
        endcase
        state_next.hv_en = state_reg.ctrl[pscw_pkg::HV_EN_BIT];
        state_next.bk_dis = state_reg.ctrl[pscw_pkg::BACKUP_DIS_BIT];
        case (state_reg.ctrl[pscw_pkg::BL_DUTY_LSB +: 2])
            2'h0: state_next.bl_duty = 7'h59;
            2'h1: state_next.bl_duty = 7'h5b;
            2'h2: state_next.bl_duty = 7'h5d;
            default: state_next.bl_duty = 7'h5f;
        endcase
        case (state_reg.ctrl[pscw_pkg::BL_CUR_LSB +: 2])
            2'h0: state_next.bl_cur = 8'h78;
            2'h1: state_next.bl_cur = 8'hc8;
            2'h2: state_next.bl_cur = 8'h50;
            default: state_next.bl_cur = 8'h00;
        endcase
        // A bad reference overrides the word.
        state_next.bl_on = stat_level[11] &&
                           (state_reg.ctrl[pscw_pkg::BL_CUR_LSB +: 2] != 2'h3);
        state_next.bl_ss_rst = !stat_level[11];
        case (state_reg.ctrl[pscw_pkg::CH3_DUTY_LSB +: 2])
            2'h0: state_next.ch3_duty = 7'h56;
            2'h1: state_next.ch3_duty = 7'h51;
            2'h2: state_next.ch3_duty = 7'h4c;
            default: state_next.ch3_duty = 7'h47;
        endcase
        state_next.ch1_duty = stat_level[13] ? pscw_pkg::FIXED_DUTY_PCT
                                             : state_next.ch3_duty;
        state_next.ch3_load_switch = &state_reg.ctrl[pscw_pkg::CH3_LOAD_SWITCH_LSB +: 2];
        state_next.ch7_boost = stat_level[12];

        if (rst) begin
            state_next = '0;
            state_next.ctrl = pscw_pkg::CTRL_RESET;
            state_next.setup = pscw_pkg::SETUP_RESET;
            state_next.trim = pscw_pkg::TRIM_RESET;
            state_next.ch1_mv = pscw_pkg::CH1_DEFAULT_MV;
            state_next.hv_mv = pscw_pkg::HV_DEFAULT_MV;
            state_next.bl_duty = pscw_pkg::BL_DUTY_DEFAULT_PCT;
            state_next.bl_cur = pscw_pkg::BL_CUR_DEFAULT;
            state_next.bl_ss_rst = 1'b1;
            state_next.ch3_duty = pscw_pkg::CH3_DUTY_DEFAULT_PCT;
            state_next.ch1_duty = pscw_pkg::CH3_DUTY_DEFAULT_PCT;
        end
    end

    always_ff @(posedge clock) begin
        state_reg <= state_next;
    end

    // Outputs.
    assign serial_dout = state_reg.dout;
    assign ch1_target_mv = state_reg.ch1_mv;
    assign ch1_code_not_recommended = state_reg.ch1_warn;
    assign hv_linear_mv = state_reg.hv_mv;
    assign hv_linear_enable = state_reg.hv_en;
    assign backup_linear_disable = state_reg.bk_dis;
    assign ch3_switched_output = state_reg.ch3_load_switch;
    assign ch7_boost_mode = state_reg.ch7_boost;
    assign control_parity = state_reg.parity;
    assign backlight_duty_pct = state_reg.bl_duty;
    assign backlight_current_tenth_ma = state_reg.bl_cur;
    assign backlight_on = state_reg.bl_on;
    assign backlight_softstart_reset = state_reg.bl_ss_rst;

    // Channel 2 has no duty field; channel 8 shares channel 3's.
    assign ch1_duty_pct = state_reg.ch1_duty;
    assign ch2_duty_pct = pscw_pkg::FIXED_DUTY_PCT;
    assign ch3_duty_pct = state_reg.ch3_duty;
    assign ch8_duty_pct = state_reg.ch3_duty;

    // Fixed non-overlap; trims only fine-tune it in the analog driver.
    assign deadtime_short_cycles = 4'(pscw_pkg::DT_SHORT_CYC);
    assign deadtime_long_cycles = 4'(pscw_pkg::DT_LONG_CYC);
    assign deadtime_trim_a = state_reg.setup[pscw_pkg::DT_A_LSB +: 2];
    assign rise_deadtime_trim_b = state_reg.setup[pscw_pkg::DT_RISE_B_LSB +: 2];
    assign rise_deadtime_trim_c = state_reg.setup[pscw_pkg::DT_RISE_C_LSB +: 2];
    assign fall_deadtime_trim_b = state_reg.setup[pscw_pkg::DT_FALL_B_LSB +: 2];
    assign fall_deadtime_trim_c = state_reg.setup[pscw_pkg::DT_FALL_C_LSB +: 2];

    assign reference_trim = state_reg.trim[pscw_pkg::REF_TRIM_LSB +: 5];
    assign oscillator_trim = state_reg.trim[pscw_pkg::OSC_TRIM_LSB +: 3];
    assign amp_gain_trim = state_reg.trim[pscw_pkg::GAIN_TRIM_LSB +: 2];
    assign amp_offset_trim = state_reg.trim[pscw_pkg::OFFS_TRIM_LSB +: 2];
    assign nv_write_strobe = state_reg.nv_strobe;
    assign nv_write_select = state_reg.nv_select;
endmodule : pscw_decoder

// >>> tb/pscw_decoder_assertions.sv
// Concurrent checks on the serial control word decoder, seen from its ports only.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module pscw_decoder_assertions (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pins
    input wire logic serial_latch,
    input wire logic ch1_buck_mode,
    input wire logic ch7_topology_select,
    input wire logic backlight_reference_pin,
    // Outputs
    input wire logic [11:0] ch1_target_mv,
    input wire logic [15:0] hv_linear_mv,
    input wire logic hv_linear_enable,
    input wire logic ch3_switched_output,
    input wire logic ch7_boost_mode,
    input wire logic backlight_on,
    input wire logic backlight_softstart_reset,
    input wire logic [6:0] ch1_duty_pct,
    input wire logic [6:0] ch2_duty_pct,
    input wire logic [6:0] ch3_duty_pct,
    input wire logic [6:0] ch8_duty_pct,
    input wire logic [3:0] deadtime_short_cycles,
    input wire logic [3:0] deadtime_long_cycles,
    input wire logic nv_write_strobe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Counts cycles since the latch pin rose; saturates so idle stretches never wrap.
    logic lat_q;
    logic [3:0] since_latch;
    always_ff @(posedge clock) begin
        lat_q <= serial_latch;
        if (rst) since_latch <= 4'hf;
        else if (serial_latch && !lat_q) since_latch <= 4'h0;
        else if (since_latch != 4'hf) since_latch <= since_latch + 4'h1;
    end
    a_reset_defaults: assert property (disable iff (1'b0) rst |=>
        ch1_target_mv == pscw_pkg::CH1_DEFAULT_MV && hv_linear_mv == pscw_pkg::HV_DEFAULT_MV
        && !hv_linear_enable) else $error("defaults missing after reset");
    a_ch2_fixed: assert property (ch2_duty_pct == pscw_pkg::FIXED_DUTY_PCT)
        else $error("ch2 duty not fixed");
    a_ch8_follows: assert property (ch8_duty_pct == ch3_duty_pct)
        else $error("ch8 duty differs from ch3");
    a_buck_duty_fixed: assert property (ch1_buck_mode [*6] |->
        ch1_duty_pct == pscw_pkg::FIXED_DUTY_PCT) else $error("ch1 buck duty wrong");
    a_ch7_boost: assert property (ch7_topology_select [*6] |-> ch7_boost_mode)
        else $error("ch7 not in step-up");
    a_backlight_forced: assert property ((!backlight_reference_pin) [*6] |->
        !backlight_on && backlight_softstart_reset) else $error("backlight not forced off");
    a_deadtime_const: assert property (deadtime_short_cycles == 4'h3
        && deadtime_long_cycles == 4'h4) else $error("dead time counts wrong");
    a_fields_at_latch: assert property ($changed(ch1_target_mv) || $changed(hv_linear_mv)
        || $changed(hv_linear_enable) |-> since_latch >= 4'h1 && since_latch <= 4'h8)
        else $error("decoded field moved without a latch");
    a_load_switch_latch: assert property ($rose(ch3_switched_output) |->
        $past(since_latch) <= 4'h7) else $error("load switch rose without a latch");
    a_nv_write_pulse: assert property (nv_write_strobe |->
        (since_latch >= 4'h1 && since_latch <= 4'h6) ##1 !nv_write_strobe)
        else $error("write strobe malformed");
    c_nv_write: cover property (nv_write_strobe);
    c_load_switch: cover property ($rose(ch3_switched_output));
    c_boost: cover property ($rose(ch7_boost_mode));
endmodule : pscw_decoder_assertions

bind pscw_decoder pscw_decoder_assertions u_chk (.*);

// >>> tb/pscw_host_model.sv
// Sub-CPU model that loads 48-bit words and reads replies over the serial pins.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/1ps
module pscw_host_model (
    // Clock
    input wire logic clock,
    // Serial pins
    output logic serial_clk,
    output logic serial_din,
    output logic serial_latch,
    output logic test_select,
    input wire logic serial_dout
);
    // Half of the link period in clocks; 120 ns is the nearest whole-clock period.
    localparam int HALF = 6;
    initial {serial_clk, serial_din, serial_latch, test_select} = 4'h0;
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask : hold
    // Bit 47 goes first; the link clock stays low outside frames.
    task automatic send(input logic [47:0] w, input logic t);
        test_select <= t;
        for (int i = 47; i >= 0; i--) begin
            serial_din <= w[i];
            hold(HALF);
            serial_clk <= 1'b1;
            hold(HALF);
            serial_clk <= 1'b0;
        end
        hold(HALF);
        serial_latch <= 1'b1;
        hold(HALF);
        serial_latch <= 1'b0;
        hold(8);
    endtask : send
    // Samples each bit just before the rising link edge, as the reply is held until a fall.
    task automatic read(output logic [47:0] r);
        for (int i = 47; i >= 0; i--) begin
            r[i] = serial_dout;
            serial_clk <= 1'b1;
            hold(HALF);
            serial_clk <= 1'b0;
            hold(HALF);
        end
    endtask : read
endmodule : pscw_host_model

// >>> tb/pscw_decoder_tb.sv
// Self-checking bench for the serial control word decoder.
// Assumes the host model drives the serial pins.
`timescale 1ns/1ps
module pscw_decoder_tb;
    logic clock, rst, serial_clk, serial_din, serial_latch, test_select, serial_dout;
    logic power_on, ch1_buck_mode, ch7_topology_select, backlight_reference_pin;
    logic [10:0] flt;
    logic [11:0] ch1_target_mv;
    logic [15:0] hv_linear_mv;
    logic [7:0] control_parity, backlight_current_tenth_ma;
    logic [6:0] backlight_duty_pct, ch1_duty_pct, ch2_duty_pct, ch3_duty_pct, ch8_duty_pct;
    logic [3:0] deadtime_short_cycles, deadtime_long_cycles;
    logic [1:0] deadtime_trim_a, rise_deadtime_trim_b, rise_deadtime_trim_c;
    logic [1:0] fall_deadtime_trim_b, fall_deadtime_trim_c, amp_gain_trim, amp_offset_trim;
    logic [4:0] reference_trim;
    logic [2:0] oscillator_trim;
    logic ch1_code_not_recommended, hv_linear_enable, backup_linear_disable, ch3_switched_output;
    logic ch7_boost_mode, backlight_on, backlight_softstart_reset, nv_write_strobe, nv_write_select;
    int err_count = 0;
    int n_tests = 0;
    localparam logic [15:0] HV_MV [4] = '{16'h34bc, 16'h30d4, 16'h2ee0, 16'h2134};
    localparam logic [6:0] BL_DUTY [4] = '{7'h59, 7'h5b, 7'h5d, 7'h5f};
    localparam logic [7:0] BL_CUR [4] = '{8'h78, 8'hc8, 8'h50, 8'h00};
    localparam logic [6:0] CH3_DUTY [4] = '{7'h56, 7'h51, 7'h4c, 7'h47};

    pscw_decoder DUT (.*, .short_fault_ch1(flt[0]), .short_fault_ch2(flt[1]),
        .short_fault_ch3(flt[2]), .short_fault_ch4(flt[3]), .short_fault_ch5(flt[4]),
        .short_fault_ch7(flt[5]), .overvolt_fault_ch2(flt[6]), .overvolt_fault_ch3(flt[7]),
        .overvolt_fault_ch6(flt[8]), .overvolt_fault_ch7(flt[9]), .thermal_fault(flt[10]));
    pscw_host_model u_host (.*);

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("compares=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    // Fault pins in bench order mapped onto the history word layout.
    function automatic logic [12:0] fault_bits(input logic [10:0] f);
        return {f[5], 1'b0, f[4:0], f[9:6], f[10], 1'b0};
    endfunction : fault_bits
    task automatic rd(input logic [2:0] code, output logic [47:0] r);
        u_host.send({code, 45'h0}, 1'b1);
        u_host.read(r);
    endtask : rd

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        repeat (40000) @(posedge clock);
        err_count++;
        print_verdict();
    end
    initial begin
        logic [47:0] w, r;
        logic [3:0] c;
        logic [12:0] e;
        rst = 1'b1;
        power_on = 1'b0;
        ch1_buck_mode = 1'b0;
        ch7_topology_select = 1'b0;
        backlight_reference_pin = 1'b1;
        flt = '0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (6) @(posedge clock);
        check(ch1_target_mv, pscw_pkg::CH1_DEFAULT_MV);
        check({hv_linear_enable, backup_linear_disable, ch3_switched_output}, 3'h0);
        check({backlight_duty_pct, backlight_current_tenth_ma}, {7'h59, 8'h78});
        check({deadtime_short_cycles, deadtime_long_cycles}, 8'h34);
        $display("reset defaults done");
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            w = {c, ~c, 8'h00, c[1:0], c[3:2], 16'h0, c, c[1:0], c[0], c[1], c[3:2], c[1:0]};
            u_host.send(w, 1'b0);
            check(ch1_target_mv, (c == 4'hf) ? 12'hb09 :
                (c < 4'h7 ? 12'haf0 : 12'hdde) - 12'(c) * 12'h032);
            check(ch1_code_not_recommended, c inside {4'h4, 4'h5, 4'h6});
            check(hv_linear_mv, HV_MV[c[1:0]]);
            check(hv_linear_enable, c[0]);
            check(backup_linear_disable, c[1]);
            check(backlight_duty_pct, BL_DUTY[c[3:2]]);
            check(backlight_current_tenth_ma, BL_CUR[c[1:0]]);
            check({ch1_duty_pct, ch3_duty_pct, ch8_duty_pct}, {3{CH3_DUTY[c[3:2]]}});
            check(ch3_switched_output, c[1:0] == 2'h3);
            check(control_parity, {c, ~c});
        end
        $display("control word decode done");
        ch1_buck_mode <= 1'b1;
        ch7_topology_select <= 1'b1;
        backlight_reference_pin <= 1'b0;
        repeat (8) @(posedge clock);
        check(ch1_duty_pct, pscw_pkg::FIXED_DUTY_PCT);
        check(ch7_boost_mode, 1'b1);
        check({backlight_on, backlight_softstart_reset}, 2'h1);
        $display("status pins done");
        w = {3'b001, 1'b0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h1, 34'h0};
        u_host.send(w, 1'b1);
        check({deadtime_trim_a, rise_deadtime_trim_b, rise_deadtime_trim_c, fall_deadtime_trim_b,
            fall_deadtime_trim_c}, 10'h1b9);
        check(nv_write_select, 1'b0);
        rd(3'b010, r);
        check(r, w);
        w = {3'b100, 5'h15, 3'h5, 2'h2, 2'h1, 33'h0};
        u_host.send(w, 1'b1);
        check({reference_trim, oscillator_trim, amp_gain_trim, amp_offset_trim}, 12'had9);
        check(nv_write_select, 1'b1);
        rd(3'b101, r);
        check(r, w);
        $display("nonvolatile words done");
        flt <= 11'h7ff;
        repeat (6) @(posedge clock);
        flt <= 11'h000;
        rd(3'b011, r);
        e = fault_bits(11'h7ff);
        check(r[47:13], {3'b011, 32'h0});
        check(r[12:6], e[12:6]);
        check(r[5:2], e[5:2]);
        check(r[1], e[1]);
        power_on <= 1'b1;
        repeat (6) @(posedge clock);
        flt <= 11'h404;
        repeat (6) @(posedge clock);
        flt <= 11'h000;
        rd(3'b011, r);
        check(r[12:0], fault_bits(11'h404));
        $display("fault history done");
        print_verdict();
    end
endmodule : pscw_decoder_tb
